// ---- core/bcc_pkg.sv ----
// constants, types and helpers shared by the charge counter files
// Operation
// [RQ1] 16-bit signed charge result readable by software
// [RQ2] result steps once per scaler converter counts
// [RQ3] reset bit clears logic and result
// [RQ4] reset bit self-clears within 40 us
// [RQ5] run bit starts, clearing stops counting
// [RQ6] stopping keeps settings and count value
// [RQ7] digital correction on unless disable bit set
// [RQ8] calibrations usable while counter runs
// [RQ9] analog calibration shorts inputs, counts offset
// [RQ10] software uses scaler one, ends calibration
// [RQ11] dither applied only with correction enabled
// [RQ12] scaler resets to one
// [RQ13] fault latches when result equals 8000 hex
// [RQ14] fault latches after 1 s undervoltage
// [RQ15] signed prescale accumulator steps result, restarts
package bcc_pkg;
    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_SCALER = 5'h04;
    localparam logic [4:0] OFS_RESULT = 5'h08;
    localparam logic [4:0] OFS_FAULT = 5'h0C;
    localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
    localparam logic [4:0] OFS_IRQ_CLR = 5'h14;
    localparam logic [4:0] OFS_IRQ_EN = 5'h18;
    localparam logic [4:0] OFS_TRIM = 5'h1C;
    ////////////////////////////////////////////////////////////////////////
    // control, fault and trim field positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_RST = 1;
    localparam int CTRL_CALDB = 2;
    localparam int CTRL_CALA = 3;
    localparam int CTRL_DITHER = 4;
    localparam int FAULT_FLAG = 0;
    localparam int FAULT_UV = 1;
    localparam int TRIM_OFS_LSB = 0;
    localparam int TRIM_GAIN_LSB = 8;
    ////////////////////////////////////////////////////////////////////////
    // widths and reset values
    localparam int SCALER_W = 15;
    localparam int RESULT_W = 16;
    localparam int SAMPLE_W = 8;
    localparam int CORR_W = 12;
    localparam int ACC_W = 18;
    localparam int GAIN_SHIFT = 7;
    localparam logic [14:0] SCALER_RST = 15'h0001;
    localparam logic [15:0] RESULT_ROLL = 16'h8000;
    localparam logic [15:0] TRIM_RST = 16'h0000;
    ////////////////////////////////////////////////////////////////////////
    // interrupt bits
    localparam int IRQ_W = 3;
    localparam int IRQ_STEP = 0;
    localparam int IRQ_RSTDONE = 1;
    localparam int IRQ_FAULT = 2;
    ////////////////////////////////////////////////////////////////////////
    // timing, 250 MHz core clock
    localparam int CLK_PERIOD_PS = 4000;
    localparam int RST_TIME_NS = 40000;
    // longest time: rounds down
    localparam int RST_CYCLES = (RST_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int DEB_TIME_S = 1;
    // least time: rounds up; product needs 64 bits
    localparam int DEB_CYCLES = int'((64'(DEB_TIME_S) * 64'hE8D4A51000
        + 64'(CLK_PERIOD_PS) - 64'h1) / 64'(CLK_PERIOD_PS));
    localparam int RST_CNT_W = 14;
    localparam int DEB_CNT_W = 28;
    ////////////////////////////////////////////////////////////////////////
    // reset sequencer states
    typedef enum logic {RS_IDLE, RS_CLEAR} bcc_rst_state_t;
    // byte-enable merge of a write into a stored word
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (wd & m);
    endfunction : be_merge
endpackage : bcc_pkg

// ---- core/bcc_prescale.sv ----
// signed prescale accumulator turning converter counts into steps
module bcc_prescale (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clr,
    input wire logic run,
    input wire logic smp_valid,
    input wire logic signed [11:0] smp,
    input wire logic [14:0] scaler,
    output logic step_up_ff,
    output logic step_dn_ff
);
    logic signed [17:0] acc_ff; // running residue
    logic signed [17:0] nxt_acc; // residue after this cycle
    logic signed [17:0] sum; // residue plus new count
    logic signed [17:0] scl; // effective scaler, never zero
    logic nxt_up; // magnitude reached, positive
    logic nxt_dn; // magnitude reached, negative

    ////////////////////////////////////////////////////////////////////////
    // one step per cycle; a large residue drains on idle cycles
    always_comb begin
        scl = signed'({3'h0, (scaler == 15'h0000) ? 15'h0001 : scaler});
        sum = acc_ff + (smp_valid ? 18'(smp) : 18'sh00000);
        nxt_up = 1'b0;
        nxt_dn = 1'b0;
        nxt_acc = sum;
        if (sum >= scl) begin
            // restart toward zero, keep remainder
            nxt_up = 1'b1; // RQ15
            nxt_acc = sum - scl;
        end else if (sum <= -scl) begin
            nxt_dn = 1'b1; // RQ15
            nxt_acc = sum + scl;
        end
    end

    // accumulator frozen while stopped, cleared by counter reset
    always_ff @(posedge core_clk) begin
        if (srst || clr) begin
            acc_ff <= 18'sh00000; // RQ3
            step_up_ff <= 1'b0;
            step_dn_ff <= 1'b0;
        end else if (run) begin
            acc_ff <= nxt_acc; // RQ2
            step_up_ff <= nxt_up;
            step_dn_ff <= nxt_dn;
        end else begin
            // hold residue so a restart continues exactly
            step_up_ff <= 1'b0; // RQ6
            step_dn_ff <= 1'b0;
        end
    end
endmodule : bcc_prescale

// ---- core/bcc_top.sv ----
// charge counter core with avalon-mm register slave
module bcc_top #(
    parameter int RST_CYC = bcc_pkg::RST_CYCLES,
    parameter int DEB_CYC = bcc_pkg::DEB_CYCLES
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic fe_sample_valid,
    input wire logic signed [7:0] fe_sample,
    input wire logic uv_detect,
    output logic fe_run,
    output logic fe_reset,
    output logic fe_short,
    output logic fe_dither,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic wait_ff; // waitrequest, high when idle
    logic [31:0] rdata_ff; // read data register
    logic wr_go; // write taken this edge
    logic [31:0] ctrl_rd; // control word as read back
    logic run_ff; // counter_run_bit
    logic rst_bit_ff; // counter_reset_bit, self clearing
    logic caldb_ff; // digital_cal_disable
    logic cala_ff; // analog_cal_enable
    logic dither_ff; // dither_enable
    logic [14:0] scaler_ff; // count_scaler
    logic [15:0] trim_ff; // digital offset and gain trim
    logic [15:0] result_ff; // charge_result
    logic fault_ff; // count_fault_flag
    logic uv_seen_ff; // undervoltage fault source seen
    logic [2:0] irq_stat_ff; // sticky event bits
    logic [2:0] irq_en_ff; // event enables
    logic [2:0] irq_set; // events this cycle
    logic [2:0] irq_clr; // software clears this cycle
    logic [13:0] rst_cnt_ff; // reset period counter
    logic rst_done; // reset period over
    logic fault_set; // any fault source this cycle
    logic fault_clr; // software clears the flag
    logic step_up; // prescaler step up
    logic step_dn; // prescaler step down
    logic uv_hit; // debounced undervoltage
    logic clearing; // digital reset active
    logic signed [11:0] corrected; // corrected converter count
    logic signed [15:0] gain_prod; // sample times gain trim
    logic [31:0] scaler_word; // scaler after byte-lane merge
    logic [31:0] trim_word; // trim after byte-lane merge
    bcc_pkg::bcc_rst_state_t rs_ff; // reset sequencer state

    ////////////////////////////////////////////////////////////////////////
    // avalon slave handshake: one wait cycle, then one ready cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wait_ff <= 1'b1;
        end else if ((avs_read || avs_write) && wait_ff) begin
            wait_ff <= 1'b0;
        end else begin
            wait_ff <= 1'b1;
        end
    end

    // write lands on the edge where waitrequest is seen low
    assign wr_go = avs_write && !wait_ff;
    assign avs_waitrequest = wait_ff;

    // control word as software sees it
    always_comb begin
        ctrl_rd = 32'h00000000;
        ctrl_rd[bcc_pkg::CTRL_RUN] = run_ff;
        ctrl_rd[bcc_pkg::CTRL_RST] = rst_bit_ff;
        ctrl_rd[bcc_pkg::CTRL_CALDB] = caldb_ff;
        ctrl_rd[bcc_pkg::CTRL_CALA] = cala_ff;
        ctrl_rd[bcc_pkg::CTRL_DITHER] = dither_ff;
    end

    // read data captured with the falling waitrequest
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata_ff <= 32'h00000000;
        end else if (avs_read && wait_ff) begin
            case (avs_address)
                bcc_pkg::OFS_CTRL: rdata_ff <= ctrl_rd;
                bcc_pkg::OFS_SCALER: rdata_ff <= {17'h00000, scaler_ff};
                // raw two's complement, upper bits zero
                bcc_pkg::OFS_RESULT: rdata_ff <= {16'h0000, result_ff}; // RQ1
                bcc_pkg::OFS_FAULT: rdata_ff <= {30'h00000000,
                                                 uv_seen_ff, fault_ff};
                bcc_pkg::OFS_IRQ_STAT: rdata_ff <= {29'h00000000,
                                                    irq_stat_ff};
                bcc_pkg::OFS_IRQ_EN: rdata_ff <= {29'h00000000, irq_en_ff};
                bcc_pkg::OFS_TRIM: rdata_ff <= {16'h0000, trim_ff};
                // unmapped and write-only offsets read zero
                default: rdata_ff <= 32'h00000000;
            endcase
        end
    end
    assign avs_readdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // control bits; run and calibration may change at any time
    always_ff @(posedge core_clk) begin
        if (srst) begin
            run_ff <= 1'b0;
            caldb_ff <= 1'b0;
            cala_ff <= 1'b0;
            dither_ff <= 1'b0;
        end else if (wr_go && avs_address == bcc_pkg::OFS_CTRL
                     && avs_byteenable[0]) begin
            run_ff <= avs_writedata[bcc_pkg::CTRL_RUN]; // RQ5
            caldb_ff <= avs_writedata[bcc_pkg::CTRL_CALDB]; // RQ7
            cala_ff <= avs_writedata[bcc_pkg::CTRL_CALA]; // RQ8
            dither_ff <= avs_writedata[bcc_pkg::CTRL_DITHER];
        end
    end

    // scaler and trim words, byte lanes honoured
    assign scaler_word = bcc_pkg::be_merge({17'h00000, scaler_ff},
        avs_writedata, avs_byteenable);
    assign trim_word = bcc_pkg::be_merge({16'h0000, trim_ff},
        avs_writedata, avs_byteenable);
    always_ff @(posedge core_clk) begin
        if (srst) begin
            scaler_ff <= bcc_pkg::SCALER_RST; // RQ12
            trim_ff <= bcc_pkg::TRIM_RST;
        end else if (wr_go) begin
            if (avs_address == bcc_pkg::OFS_SCALER) begin
                scaler_ff <= scaler_word[14:0];
            end
            if (avs_address == bcc_pkg::OFS_TRIM) begin
                trim_ff <= trim_word[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset sequencer: the bit stays set for the whole period
    assign rst_done = rs_ff == bcc_pkg::RS_CLEAR
        && rst_cnt_ff == 14'(RST_CYC - 1);
    assign clearing = rs_ff == bcc_pkg::RS_CLEAR;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rs_ff <= bcc_pkg::RS_IDLE;
            rst_bit_ff <= 1'b0;
            rst_cnt_ff <= 14'h0000;
        end else if (wr_go && avs_address == bcc_pkg::OFS_CTRL
                     && avs_byteenable[0]
                     && avs_writedata[bcc_pkg::CTRL_RST]) begin
            // a new request restarts the period
            rs_ff <= bcc_pkg::RS_CLEAR; // RQ3
            rst_bit_ff <= 1'b1;
            rst_cnt_ff <= 14'h0000;
        end else begin
            case (rs_ff)
                bcc_pkg::RS_IDLE: begin
                    rst_cnt_ff <= 14'h0000;
                end
                bcc_pkg::RS_CLEAR: begin
                    if (rst_done) begin
                        rs_ff <= bcc_pkg::RS_IDLE;
                        rst_bit_ff <= 1'b0; // RQ4
                    end else begin
                        rst_cnt_ff <= rst_cnt_ff + 14'h0001;
                    end
                end
                default: begin
                    rs_ff <= bcc_pkg::RS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // digital offset and gain correction of each count
    assign gain_prod = 16'(fe_sample) * 16'(signed'(trim_ff[15:8]));

    always_comb begin
        if (caldb_ff) begin
            // correction off: raw counts go straight through
            corrected = 12'(fe_sample); // RQ7
        end else begin
            corrected = 12'(fe_sample)
                - 12'(signed'(trim_ff[7:0]))
                + 12'(gain_prod >>> bcc_pkg::GAIN_SHIFT); // RQ7
        end
    end

    // prescaler counts scaler units of corrected counts
    bcc_prescale u_prescale (
        .core_clk(core_clk),
        .srst(srst),
        .clr(clearing),
        .run(run_ff),
        .smp_valid(fe_sample_valid),
        .smp(corrected),
        .scaler(scaler_ff),
        .step_up_ff(step_up),
        .step_dn_ff(step_dn)
    );

    // undervoltage must persist before it counts as battery removal
    bcc_uv_debounce #(
        .DEB_CYC(DEB_CYC)
    ) u_uv_debounce (
        .core_clk(core_clk),
        .srst(srst),
        .uv_level(uv_detect),
        .hit_ff(uv_hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // charge result counter; wraps, fault flag marks the wrap
    always_ff @(posedge core_clk) begin
        if (srst || clearing) begin
            result_ff <= 16'h0000; // RQ3
        end else if (run_ff && step_up) begin
            result_ff <= result_ff + 16'h0001; // RQ2
        end else if (run_ff && step_dn) begin
            result_ff <= result_ff - 16'h0001; // RQ2
        end
    end

    // fault flag: hardware set beats software clear
    assign fault_set = result_ff == bcc_pkg::RESULT_ROLL || uv_hit;
    assign fault_clr = wr_go && avs_address == bcc_pkg::OFS_FAULT
        && avs_byteenable[0] && avs_writedata[bcc_pkg::FAULT_FLAG];

    always_ff @(posedge core_clk) begin
        if (srst) begin
            fault_ff <= 1'b0;
            uv_seen_ff <= 1'b0;
        end else begin
            if (fault_set) begin
                fault_ff <= 1'b1; // RQ13
            end else if (fault_clr) begin
                fault_ff <= 1'b0;
            end
            if (uv_hit) begin
                uv_seen_ff <= 1'b1; // RQ14
            end else if (fault_clr) begin
                uv_seen_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status: sticky, write-one-to-clear, set wins
    assign irq_set[bcc_pkg::IRQ_STEP] = run_ff && (step_up || step_dn);
    assign irq_set[bcc_pkg::IRQ_RSTDONE] = rst_done;
    assign irq_set[bcc_pkg::IRQ_FAULT] = fault_set && !fault_ff;
    assign irq_clr = (wr_go && avs_address == bcc_pkg::OFS_IRQ_CLR
        && avs_byteenable[0]) ? avs_writedata[2:0] : 3'h0;

    for (genvar i = 0; i < bcc_pkg::IRQ_W; i++) begin : g_irq
        always_ff @(posedge core_clk) begin
            if (srst) begin
                irq_stat_ff[i] <= 1'b0;
            end else if (irq_set[i]) begin
                irq_stat_ff[i] <= 1'b1;
            end else if (irq_clr[i]) begin
                irq_stat_ff[i] <= 1'b0;
            end
        end
    end

    // enables and the registered level output
    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_en_ff <= 3'h0;
            irq <= 1'b0;
        end else begin
            if (wr_go && avs_address == bcc_pkg::OFS_IRQ_EN
                && avs_byteenable[0]) begin
                irq_en_ff <= avs_writedata[2:0];
            end
            irq <= |(irq_stat_ff & irq_en_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // front-end controls, all registered
    always_ff @(posedge core_clk) begin
        if (srst) begin
            fe_run <= 1'b0;
            fe_reset <= 1'b0;
            fe_short <= 1'b0;
            fe_dither <= 1'b0;
        end else begin
            fe_run <= run_ff; // RQ5
            fe_reset <= clearing; // RQ3
            // shorted inputs leave only the analog offset to count
            fe_short <= cala_ff; // RQ9
            // dither is useless without the digital correction
            fe_dither <= dither_ff && !caldb_ff; // RQ11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_rst_write;
        wr_go && avs_address == bcc_pkg::OFS_CTRL && avs_byteenable[0]
            && avs_writedata[bcc_pkg::CTRL_RST];
    endsequence

    a_reset_starts: assert property (s_rst_write |=> rst_bit_ff ##1 // RQ3
        result_ff == 16'h0000) else $error("reset write did not clear");
    a_reset_bounded: assert property (rst_bit_ff |-> // RQ4
        rst_cnt_ff < 14'(RST_CYC)) else $error("reset period too long");
    a_step_up_one: assert property (run_ff && step_up && !clearing // RQ2
        |=> result_ff == $past(result_ff) + 16'h0001)
        else $error("result did not step up");
    a_stop_holds: assert property (!run_ff && !clearing // RQ6
        |=> $stable(result_ff)) else $error("result moved while stopped");
    a_roll_fault: assert property (result_ff == bcc_pkg::RESULT_ROLL // RQ13
        |=> fault_ff ##1 (fault_ff || $past(fault_clr)))
        else $error("rollover fault not latched");
    a_uv_fault: assert property (uv_hit |=> fault_ff && uv_seen_ff) // RQ14
        else $error("undervoltage fault not latched");
    a_dither_gate: assert property (fe_dither |-> // RQ11
        $past(dither_ff) && !$past(caldb_ff)) else $error("dither leak");
    a_short_follow: assert property ($rose(cala_ff) |=> fe_short) // RQ9
        else $error("inputs not shorted");
    a_raw_counts: assert property (caldb_ff |-> // RQ7
        corrected == 12'(fe_sample)) else $error("correction not bypassed");
    a_bus_answer: assert property ((avs_read || avs_write) && wait_ff
        |=> !wait_ff ##1 wait_ff) else $error("bus answer timing");
endmodule : bcc_top

// ---- core/bcc_uv_debounce.sv ----
// long debounce of the supply undervoltage level
module bcc_uv_debounce #(
    parameter int DEB_CYC = bcc_pkg::DEB_CYCLES
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic uv_level,
    output logic hit_ff
);
    logic [27:0] cnt_ff; // cycles the level has held
    logic done_ff; // one hit per undervoltage episode

    ////////////////////////////////////////////////////////////////////////
    // short dips restart the count and never reach the hit
    always_ff @(posedge core_clk) begin
        if (srst || !uv_level) begin
            cnt_ff <= 28'h0000000;
            done_ff <= 1'b0;
            hit_ff <= 1'b0;
        end else if (!done_ff && cnt_ff == 28'(DEB_CYC - 1)) begin
            hit_ff <= 1'b1; // RQ14
            done_ff <= 1'b1;
        end else begin
            hit_ff <= 1'b0;
            if (!done_ff) begin
                cnt_ff <= cnt_ff + 28'h0000001;
            end
        end
    end
endmodule : bcc_uv_debounce

// ---- verif/battery_charge_counter_tb.sv ----
// self-checking bench for the charge counter core
module battery_charge_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RC = 8; // short reset period
    localparam int DC = 16; // short undervoltage debounce
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata, rdv;
    logic avs_waitrequest, fe_sample_valid, fe_run, fe_reset;
    logic fe_short, fe_dither, irq;
    logic signed [7:0] fe_sample;
    logic signed [7:0] level = 8'h00;
    logic uv_detect = 1'b0;
    logic req = 1'b0;
    logic [15:0] er = 16'h0; // expected result
    int n_mismatch = 0, n_compared = 0, seed = 76, acc = 0, sc = 1, s;
    always #2 core_clk = ~core_clk;
    bcc_top #(.RST_CYC(RC), .DEB_CYC(DC)) uut (.core_clk(core_clk),
        .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .fe_sample_valid(fe_sample_valid), .fe_sample(fe_sample),
        .uv_detect(uv_detect), .fe_run(fe_run), .fe_reset(fe_reset),
        .fe_short(fe_short), .fe_dither(fe_dither), .irq(irq));
    bcc_fe_model fe (.core_clk(core_clk), .fe_short(fe_short), .req(req),
        .level(level), .fe_sample_valid(fe_sample_valid),
        .fe_sample(fe_sample));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one avalon transfer; held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        // a slave that never answers is ended by the watchdog
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    // one converter count, then a gap so the residue drains
    task automatic send(input int v, input int gap);
        @(posedge core_clk);
        req <= 1'b1;
        level <= 8'(v);
        @(posedge core_clk);
        req <= 1'b0;
        repeat (gap) @(posedge core_clk);
    endtask : send
    // reference prescaler: residue kept, one step per scaler counts
    function automatic void ex(input int v);
        acc += v;
        while (acc >= sc) begin acc -= sc; er++; end
        while (acc <= -sc) begin acc += sc; er--; end
    endfunction : ex
    task automatic rd_res();
        bus(0, bcc_pkg::OFS_RESULT, 0);
    endtask : rd_res
    // counter reset, waiting out the period
    task automatic crst(input logic [31:0] ctl);
        bus(1, bcc_pkg::OFS_CTRL, ctl | 32'h2);
        repeat (RC + 4) @(posedge core_clk);
        er = 16'h0;
        acc = 0;
    endtask : crst
    task automatic final_report();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////
    // watchdog sized well past the rollover run
    initial begin
        repeat (60000) @(posedge core_clk);
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        bus(0, bcc_pkg::OFS_SCALER, 0); chk(rdv, 32'h1);
        rd_res(); chk(rdv, 32'h0);
        bus(0, 5'h01, 0); chk(rdv, 32'h0);
        bus(0, bcc_pkg::OFS_IRQ_CLR, 0); chk(rdv, 32'h0);
        $display("reset values done");
        bus(1, bcc_pkg::OFS_IRQ_EN, 32'h7);
        bus(1, bcc_pkg::OFS_CTRL, 32'h1);
        repeat (4) begin
            sc = 1 + ($random(seed) & 7);
            bus(1, bcc_pkg::OFS_SCALER, 32'(sc));
            ex(0);
            repeat (8) begin
                s = $random(seed) % 4;
                send(s, 6);
                ex(s);
            end
            rd_res(); chk(rdv, {16'h0, er});
        end
        bus(1, bcc_pkg::OFS_CTRL, 32'h0);
        send(3, 6);
        send(-2, 6);
        rd_res(); chk(rdv, {16'h0, er});
        chk(fe_run, 1'b0);
        bus(1, bcc_pkg::OFS_CTRL, 32'h1);
        send(2, 6);
        ex(2);
        rd_res(); chk(rdv, {16'h0, er});
        $display("counting and stop done");
        bus(1, bcc_pkg::OFS_CTRL, 32'h3);
        bus(0, bcc_pkg::OFS_CTRL, 0); chk(rdv, 32'h3);
        rd_res(); chk(rdv, 32'h0);
        chk(fe_reset, 1'b1);
        repeat (RC + 2) @(posedge core_clk);
        bus(0, bcc_pkg::OFS_CTRL, 0); chk(rdv, 32'h1);
        chk(fe_reset, 1'b0);
        chk(fe_run, 1'b1);
        bus(0, bcc_pkg::OFS_IRQ_STAT, 0); chk(rdv[1], 1'b1);
        $display("counter reset done");
        bus(1, bcc_pkg::OFS_TRIM, 32'h4000);
        bus(1, bcc_pkg::OFS_SCALER, 32'h6);
        crst(32'h1);
        sc = 6;
        repeat (3) begin send(4, 6); ex(6); end
        rd_res(); chk(rdv, {16'h0, er});
        crst(32'h5);
        repeat (3) begin send(4, 6); ex(4); end
        rd_res(); chk(rdv, {16'h0, er});
        bus(1, bcc_pkg::OFS_TRIM, 32'h0);
        for (int k = 0; k < 8; k++) begin
            bus(1, bcc_pkg::OFS_CTRL, {27'h0, 3'(k), 2'b01});
            repeat (2) @(negedge core_clk);
            chk(fe_dither, k[2] & ~k[0]);
            chk(fe_short, k[1]);
        end
        $display("correction and flags done");
        bus(1, bcc_pkg::OFS_SCALER, 32'h1);
        sc = 1;
        crst(32'h9);
        repeat (5) begin send(50, 6); ex(-2); end
        rd_res(); chk(rdv, {16'h0, er});
        crst(32'h1);
        repeat (256) begin send(-128, 132); ex(-128); end
        rd_res(); chk(rdv, 32'h8000);
        bus(0, bcc_pkg::OFS_FAULT, 0); chk(rdv, 32'h1);
        chk(irq, 1'b1);
        bus(1, bcc_pkg::OFS_IRQ_CLR, 32'h7);
        bus(0, bcc_pkg::OFS_IRQ_STAT, 0); chk(rdv, 32'h0);
        bus(1, bcc_pkg::OFS_FAULT, 32'h1);
        bus(0, bcc_pkg::OFS_FAULT, 0); chk(rdv, 32'h1);
        send(1, 6);
        bus(1, bcc_pkg::OFS_FAULT, 32'h1);
        bus(0, bcc_pkg::OFS_FAULT, 0); chk(rdv, 32'h0);
        rd_res(); chk(rdv, 32'h8001);
        bus(1, bcc_pkg::OFS_IRQ_EN, 32'h0);
        repeat (2) @(negedge core_clk);
        chk(irq, 1'b0);
        $display("rollover fault done");
        @(posedge core_clk) uv_detect <= 1'b1;
        repeat (DC - 4) @(posedge core_clk);
        uv_detect <= 1'b0;
        bus(0, bcc_pkg::OFS_FAULT, 0); chk(rdv, 32'h0);
        @(posedge core_clk) uv_detect <= 1'b1;
        repeat (DC + 4) @(posedge core_clk);
        uv_detect <= 1'b0;
        bus(0, bcc_pkg::OFS_FAULT, 0); chk(rdv, 32'h3);
        $display("undervoltage fault done");
        final_report();
    end
endmodule : battery_charge_counter_tb

// ---- verif/bcc_fe_model.sv ----
// behavioural converter front end feeding counts to the charge counter
module bcc_fe_model #(
    parameter logic signed [7:0] SHORT_OFS = 8'hFE // residual offset
) (
    input wire logic core_clk,
    input wire logic fe_short,
    input wire logic req,
    input wire logic signed [7:0] level,
    output logic fe_sample_valid,
    output logic signed [7:0] fe_sample
);
    timeunit 1ns;
    timeprecision 1ps;
    initial fe_sample_valid = 1'b0;
    initial fe_sample = 8'h5A;
    // one count per request; shorted inputs see only the offset
    always @(posedge core_clk) begin
        fe_sample_valid <= req;
        if (req) begin
            fe_sample <= fe_short ? SHORT_OFS : level;
        end else begin
            // data not valid: keep it moving so nobody relies on it
            fe_sample <= ~fe_sample;
        end
    end
endmodule : bcc_fe_model
